// ===== hciu_pkg.sv
package hciu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and baud timing
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned BAUD_MIN        = 9600;
   localparam int unsigned BAUD_MAX        = 4_000_000;
   localparam int unsigned BAUD_DEFAULT    = 115200;
   localparam int unsigned OSR             = 16;
   localparam int unsigned DIV_W           = 16;
   // Divider in clock cycles per oversample tick, rounded to nearest
   localparam logic [DIV_W-1:0] DIV_DEFAULT =
      DIV_W'((CLK_HZ + (BAUD_DEFAULT * OSR) / 2) / (BAUD_DEFAULT * OSR));
   localparam logic [DIV_W-1:0] DIV_MIN_TICK = 16'h0001;
   localparam logic [DIV_W-1:0] DIV_MAX_TICK =
      DIV_W'(CLK_HZ / (BAUD_MIN * OSR));
   localparam logic [3:0] OSR_LAST  = 4'hf;
   localparam logic [3:0] OSR_MID   = 4'h7;
   localparam logic [3:0] BIT_LAST  = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // FIFO sizing
   localparam int unsigned FIFO_DEPTH  = 1040;
   localparam int unsigned FIFO_AW     = 11;
   localparam logic [FIFO_AW:0] RTS_THR_DEFAULT = 12'h010;

   ////////////////////////////////////////////////////////////////////////////
   // Special characters
   localparam logic [7:0] CH_XON     = 8'h11;
   localparam logic [7:0] CH_XOFF    = 8'h13;
   localparam logic [7:0] CH_END     = 8'hc0;
   localparam logic [7:0] CH_ESC     = 8'hdb;
   localparam logic [7:0] CH_ESC_END = 8'hdc;
   localparam logic [7:0] CH_ESC_ESC = 8'hdd;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_BAUD    = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_TXDATA  = 8'h0c;
   localparam logic [7:0] REG_RXDATA  = 8'h10;
   localparam logic [7:0] REG_RTSTHR  = 8'h14;
   localparam logic [7:0] REG_AUTOBD  = 8'h18;
   localparam logic [7:0] REG_LEVEL   = 8'h1c;

   // Control bit positions
   localparam int unsigned C_EN      = 0;
   localparam int unsigned C_THREEW  = 1;
   localparam int unsigned C_XONOFF  = 2;
   localparam int unsigned C_SLIP    = 3;
   localparam int unsigned C_AUTOBD  = 4;
   localparam int unsigned C_SLEEP   = 5;
   localparam logic [5:0]  CTRL_RESET = 6'h01;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hciu_byte_t;

   // Free space in a FIFO of the given level
   function automatic logic [FIFO_AW:0] hciu_free(input logic [FIFO_AW:0] lvl);
      return FIFO_AW'(FIFO_DEPTH) - lvl;
   endfunction : hciu_free

endpackage : hciu_pkg

// ===== hciu_fifo.sv
`timescale 1ns/10ps
module hciu_fifo
   import hciu_pkg::*;
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = FIFO_DEPTH,
   parameter int unsigned AW    = FIFO_AW
) (
   input  wire logic             pclk,      // Clock
   input  wire logic             presetn,   // Async reset, low
   input  wire logic             wr_valid,  // Write request
   output      logic             wr_ready,  // Space available
   input  wire logic [WIDTH-1:0] wr_data,   // Write data
   output      logic             rd_valid,  // Data available
   input  wire logic             rd_ready,  // Read accept
   output      logic [WIDTH-1:0] rd_data,   // Head data
   output      logic [AW:0]      level      // Stored words
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   wire              do_wr = wr_valid && wr_ready;
   wire              do_rd = rd_valid && rd_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Flags from level
   assign wr_ready = (level != AW'(DEPTH));
   assign rd_valid = (level != '0);
   assign rd_data  = mem[rp];

   // Pointer wrap
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   // Storage
   always_ff @(posedge pclk) begin
      if (do_wr) begin
         mem[wp] <= wr_data;
      end
   end

   // Pointers and level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else begin
         if (do_wr) wp <= bump(wp);
         if (do_rd) rp <= bump(rp);
         level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

endmodule : hciu_fifo

// ===== hciu_autobaud.sv
`timescale 1ns/10ps
module hciu_autobaud
   import hciu_pkg::*;
(
   input  wire logic             pclk,     // Clock
   input  wire logic             presetn,  // Async reset, low
   input  wire logic             arm,      // Detection enabled
   input  wire logic             rxd,      // Receive line
   output      logic             done,     // One-cycle result pulse
   output      logic [DIV_W-1:0] div       // Measured tick divider
);

   typedef enum logic [1:0] {AB_IDLE, AB_LOW, AB_WAIT} hciu_ab_t;
   hciu_ab_t         st;
   logic [DIV_W+3:0] cnt;
   logic             rxd_q;
   // Round to the nearest tick; the edge capture loses one cycle of the low time
   wire  [DIV_W+3:0] cnt_rnd = cnt + (DIV_W+4)'(OSR / 2);

   ////////////////////////////////////////////////////////////////////////////
   // Measure the start bit low time of the first character
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st    <= AB_IDLE;
         cnt   <= '0;
         done  <= 1'b0;
         div   <= DIV_DEFAULT;
         rxd_q <= 1'b1;
      end else begin
         rxd_q <= rxd;
         done  <= 1'b0;
         unique case (st)
            AB_IDLE: begin
               cnt <= '0;
               if (arm && rxd_q && !rxd) st <= AB_LOW;
            end
            AB_LOW: begin
               cnt <= cnt + 1'b1;
               if (rxd) begin
                  div  <= (cnt_rnd[DIV_W+3:4] == '0) ? DIV_MIN_TICK : cnt_rnd[DIV_W+3:4];
                  done <= 1'b1;
                  st   <= AB_WAIT;
               end
            end
            AB_WAIT: begin
               if (!arm) st <= AB_IDLE;
            end
         endcase
      end
   end

endmodule : hciu_autobaud

// ===== hciu_uart.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - Four-wire port of receive, transmit, request and clear lines
// - Programmable rate from 9600 bps to 4.0 Mbps
// - Automatic rate detection yields a divider
// - Host may set the rate by command instead
// - Separate 1040-byte receive and transmit FIFOs
// - FIFOs reachable from the bus by processor or DMA
// - Supports H4 and H5 transport layers
// - Runs at 115.2 Kbaud after reset
// - Three-wire mode ignores request and clear lines
// - XOFF pauses and XON resumes transmission
// - SLIP escaping and unescaping in hardware
// - Line activity during sleep raises a wake event
// - Rate from configuration record or detection
// - Host may rewrite divider during operation
// - Combined rate error of both sides within 2 percent
// - Actual rates close to requested, nearest-divider rounding
// - Transmit valid within 1.5 bits of clear going low
// - Clear high by stop midpoint holds the next character
// - Request goes high by 0.5 bit after stop midpoint
module hciu_uart
   import hciu_pkg::*;
(
   input  wire logic        pclk,        // Clock, 125 MHz
   input  wire logic        presetn,     // Async reset, low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output      logic [31:0] prdata,      // APB read data
   output      logic        pready,      // APB ready
   output      logic        pslverr,     // APB error
   input  wire logic        uart_rxd,    // Serial receive
   output      logic        uart_txd,    // Serial transmit
   input  wire logic        uart_cts_n,  // Clear to send, low
   output      logic        uart_rts_n,  // Request to send, low
   output      logic        wake         // Wake event level
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [5:0]       ctrl;
   logic [DIV_W-1:0] baud_div;
   logic [FIFO_AW:0] rts_thr;
   logic             rx_ovf;
   logic             rx_ferr;
   logic             xoff_held;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire apb_acc  = psel && penable;
   wire apb_wr   = apb_acc && pwrite;
   wire apb_rd   = apb_acc && !pwrite;
   wire hit_ctrl = (paddr == REG_CTRL);
   wire hit_baud = (paddr == REG_BAUD);
   wire hit_stat = (paddr == REG_STATUS);
   wire hit_tx   = (paddr == REG_TXDATA);
   wire hit_rx   = (paddr == REG_RXDATA);
   wire hit_thr  = (paddr == REG_RTSTHR);
   wire hit_ab   = (paddr == REG_AUTOBD);
   wire hit_lvl  = (paddr == REG_LEVEL);
   wire hit_any  = hit_ctrl | hit_baud | hit_stat | hit_tx | hit_rx | hit_thr
                 | hit_ab | hit_lvl;
   wire en       = ctrl[C_EN];
   wire threew   = ctrl[C_THREEW];
   wire slip_on  = ctrl[C_SLIP];

   ////////////////////////////////////////////////////////////////////////////
   // FIFOs
   logic             txf_valid;
   logic             txf_wready;
   logic [7:0]       txf_data;
   logic             txf_pop;
   logic [FIFO_AW:0] txf_lvl;
   logic             rxf_valid;
   logic             rxf_wready;
   logic [7:0]       rxf_data;
   logic [FIFO_AW:0] rxf_lvl;
   hciu_byte_t       rx_push;
   wire              rxf_pop = apb_rd && hit_rx && rxf_valid;
   wire              txf_put = apb_wr && hit_tx && txf_wready;

   // Transmit FIFO, filled by bus writes
   hciu_fifo #(.WIDTH(8)) u_txf (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_valid (txf_put),
      .wr_ready (txf_wready),
      .wr_data  (pwdata[7:0]),
      .rd_valid (txf_valid),
      .rd_ready (txf_pop),
      .rd_data  (txf_data),
      .level    (txf_lvl)
   );

   // Receive FIFO, drained by bus reads
   hciu_fifo #(.WIDTH(8)) u_rxf (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_valid (rx_push.valid),
      .wr_ready (rxf_wready),
      .wr_data  (rx_push.data),
      .rd_valid (rxf_valid),
      .rd_ready (rxf_pop),
      .rd_data  (rxf_data),
      .level    (rxf_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Autobaud
   logic             ab_done;
   logic [DIV_W-1:0] ab_div;
   hciu_autobaud u_ab (
      .pclk    (pclk),
      .presetn (presetn),
      .arm     (ctrl[C_AUTOBD]),
      .rxd     (uart_rxd),
      .done    (ab_done),
      .div     (ab_div)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Oversample tick divider
   logic [DIV_W-1:0] tick_cnt;
   wire              tick = en && (tick_cnt == '0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_cnt <= '0;
      else if (tick || !en) tick_cnt <= baud_div - 1'b1;
      else tick_cnt <= tick_cnt - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; the divider reloads from host command or detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= CTRL_RESET;
         baud_div <= DIV_DEFAULT;
         rts_thr  <= RTS_THR_DEFAULT;
      end else begin
         if (apb_wr && hit_ctrl) ctrl <= pwdata[5:0];
         if (apb_wr && hit_baud && pwdata[DIV_W-1:0] != '0) begin
            baud_div <= pwdata[DIV_W-1:0];
         end else if (ab_done) begin
            baud_div <= ab_div;
         end
         if (ab_done) ctrl[C_AUTOBD] <= 1'b0;
         if (apb_wr && hit_thr) rts_thr <= pwdata[FIFO_AW:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hciu_rx_t;
   hciu_rx_t   rx_st;
   logic [3:0] rx_os;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh;
   logic       rx_esc;
   wire        rx_mid  = tick && (rx_os == OSR_MID);
   wire        rx_stop_mid = rx_mid && (rx_st == RX_STOP);
   wire        rx_good = rx_stop_mid && uart_rxd;
   wire        rx_is_x = ctrl[C_XONOFF] && (rx_sh == CH_XON || rx_sh == CH_XOFF);
   wire        rx_slip_esc  = slip_on && (rx_sh == CH_ESC);
   wire [7:0]  rx_unesc = (rx_sh == CH_ESC_END) ? CH_END :
                          (rx_sh == CH_ESC_ESC) ? CH_ESC : rx_sh;
   wire [7:0]  rx_out   = (slip_on && rx_esc) ? rx_unesc : rx_sh;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st  <= RX_IDLE;
         rx_os  <= '0;
         rx_bit <= '0;
         rx_sh  <= '0;
      end else if (tick) begin
         rx_os <= rx_os + 1'b1;
         unique case (rx_st)
            RX_IDLE: begin
               rx_os <= '0;
               if (!uart_rxd) rx_st <= RX_START;
            end
            RX_START: if (rx_os == OSR_MID) begin
               rx_os <= '0;
               rx_st <= uart_rxd ? RX_IDLE : RX_DATA;
               rx_bit <= '0;
            end
            RX_DATA: if (rx_os == OSR_LAST) begin
               rx_sh  <= {uart_rxd, rx_sh[7:1]};
               rx_bit <= rx_bit + 1'b1;
               if (rx_bit == BIT_LAST) rx_st <= RX_STOP;
            end
            RX_STOP: if (rx_os == OSR_MID) rx_st <= RX_IDLE;
         endcase
      end
   end

   // Receive byte routing, flow characters, SLIP and error flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_push   <= '0;
         rx_esc    <= 1'b0;
         xoff_held <= 1'b0;
         rx_ovf    <= 1'b0;
         rx_ferr   <= 1'b0;
      end else begin
         rx_push.valid <= 1'b0;
         if (rx_good && rx_is_x) begin
            xoff_held <= (rx_sh == CH_XOFF);
         end else if (rx_good && rx_slip_esc && !rx_esc) begin
            rx_esc <= 1'b1;
         end else if (rx_good) begin
            rx_esc        <= 1'b0;
            rx_push.valid <= rxf_wready;
            rx_push.data  <= rx_out;
         end
         if (!ctrl[C_XONOFF]) xoff_held <= 1'b0;
         // Sticky errors: a new event wins over the clear
         if (rx_good && !rx_is_x && !rxf_wready) rx_ovf <= 1'b1;
         else if (apb_wr && hit_stat && pwdata[0]) rx_ovf <= 1'b0;
         if (rx_stop_mid && !uart_rxd) rx_ferr <= 1'b1;
         else if (apb_wr && hit_stat && pwdata[1]) rx_ferr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request to send, updated every clock from receive FIFO free space against the threshold
   wire rts_block = hciu_free(rxf_lvl) < rts_thr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) uart_rts_n <= 1'b1;
      else if (threew || !en) uart_rts_n <= 1'b1;
      else uart_rts_n <= rts_block;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hciu_tx_t;
   hciu_tx_t   tx_st;
   logic [3:0] tx_os;
   logic [3:0] tx_bit;
   logic [7:0] tx_sh;
   logic       tx_pend_esc;
   logic [7:0] tx_pend;
   wire        cts_ok  = threew || !uart_cts_n;
   wire        tx_go   = cts_ok && !xoff_held;
   wire        tx_need_esc = slip_on && (txf_data == CH_END || txf_data == CH_ESC);
   wire [7:0]  tx_esc_code = (txf_data == CH_END) ? CH_ESC_END : CH_ESC_ESC;
   wire        tx_load = tick && (tx_st == TX_IDLE) && tx_go && (tx_pend_esc || txf_valid);
   assign      txf_pop = tx_load && !tx_pend_esc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st       <= TX_IDLE;
         tx_os       <= '0;
         tx_bit      <= '0;
         tx_sh       <= '0;
         tx_pend_esc <= 1'b0;
         tx_pend     <= '0;
         uart_txd    <= 1'b1;
      end else if (tick) begin
         tx_os <= tx_os + 1'b1;
         unique case (tx_st)
            TX_IDLE: begin
               tx_os    <= '0;
               uart_txd <= 1'b1;
               if (tx_load) begin
                  // Start within one tick of clear going low
                  tx_st    <= TX_START;
                  uart_txd <= 1'b0;
                  if (tx_pend_esc) begin
                     tx_sh       <= tx_pend;
                     tx_pend_esc <= 1'b0;
                  end else if (tx_need_esc) begin
                     tx_sh       <= CH_ESC;
                     tx_pend     <= tx_esc_code;
                     tx_pend_esc <= 1'b1;
                  end else begin
                     tx_sh <= txf_data;
                  end
               end
            end
            TX_START: if (tx_os == OSR_LAST) begin
               tx_st    <= TX_DATA;
               tx_bit   <= '0;
               uart_txd <= tx_sh[0];
            end
            TX_DATA: if (tx_os == OSR_LAST) begin
               tx_bit   <= tx_bit + 1'b1;
               if (tx_bit == BIT_LAST) begin
                  tx_st    <= TX_STOP;
                  uart_txd <= 1'b1;
               end else begin
                  uart_txd <= tx_sh[tx_bit[2:0] + 3'h1];
               end
            end
            TX_STOP: if (tx_os == OSR_LAST) tx_st <= TX_IDLE;
         endcase
      end else if (!en) begin
         tx_st    <= TX_IDLE;
         uart_txd <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake on line activity while asleep; write one to status bit 2 clears
   wire line_act = !uart_rxd || (!threew && !uart_cts_n);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wake <= 1'b0;
      else if (ctrl[C_SLEEP] && line_act) wake <= 1'b1;
      else if ((apb_wr && hit_stat && pwdata[2]) || !ctrl[C_SLEEP]) wake <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and APB answer
   wire [31:0] rd_mux =
      hit_ctrl ? {26'h0, ctrl} :
      hit_baud ? {16'h0, baud_div} :
      hit_stat ? {24'h0, tx_st != TX_IDLE, xoff_held, !txf_wready, rxf_valid,
                  !uart_rts_n, wake, rx_ferr, rx_ovf} :
      hit_rx   ? {23'h0, rxf_valid, rxf_data} :
      hit_thr  ? {20'h0, rts_thr} :
      hit_ab   ? {15'h0, ctrl[C_AUTOBD], ab_div} :
      hit_lvl  ? {4'h0, txf_lvl, 4'h0, rxf_lvl} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : '0;
      end
   end

endmodule : hciu_uart

// ===== hciu_uart_chk.sv
`timescale 1ns/10ps
module hciu_uart_chk
   import hciu_pkg::*;
(
   input wire logic        pclk,        // Clock
   input wire logic        presetn,     // Reset, low
   input wire logic        psel,        // APB select
   input wire logic        penable,     // APB enable
   input wire logic        pwrite,      // APB direction
   input wire logic [7:0]  paddr,       // APB address
   input wire logic [31:0] pwdata,      // APB write data
   input wire logic [31:0] prdata,      // APB read data
   input wire logic        pready,      // APB ready
   input wire logic        pslverr,     // APB error
   input wire logic        uart_rxd,    // Serial in
   input wire logic        uart_txd,    // Serial out
   input wire logic        uart_cts_n,  // Clear, low
   input wire logic        uart_rts_n,  // Request, low
   input wire logic        wake         // Wake level
);
   logic [5:0]  ctrl_q;
   logic [15:0] div_q;
   logic [11:0] thr_q;
   int          lowrun;
   int          bitlen;
   // Bus and settings decodes
   wire         wr_hit = psel && penable && pready && pwrite;
   wire         setup  = psel && !penable;
   wire         mapped = paddr <= REG_LEVEL && paddr[1:0] == 2'b00;
   wire         room   = ctrl_q[C_EN] && !ctrl_q[C_THREEW] && thr_q == 12'h000;
   wire         stir   = !uart_rxd || (!uart_cts_n && !ctrl_q[C_THREEW]);
   assign bitlen = int'(div_q) * 16;

   ////////////////////////////////////////////////////////////////////////////
   // Shadowed settings; zero divider refused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
         div_q  <= DIV_DEFAULT;
         thr_q  <= RTS_THR_DEFAULT;
      end else if (wr_hit) begin
         if (paddr == REG_CTRL) ctrl_q <= pwdata[5:0];
         if (paddr == REG_BAUD && pwdata[15:0] != 16'h0000) div_q <= pwdata[15:0];
         if (paddr == REG_RTSTHR) thr_q <= pwdata[11:0];
      end
   end

   // Low run on transmit line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lowrun <= 0;
      else lowrun <= uart_txd ? 0 : lowrun + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   pready_after_setup_a: assert property (setup |=> pready)
      else $error("no ready");
   pready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held");
   rdata_quiet_a: assert property (!pready |-> prdata == 32'h0)
      else $error("stray read data");
   slverr_unmapped_a: assert property (setup && !mapped |=> pslverr)
      else $error("no error unmapped");
   slverr_mapped_a: assert property (setup && mapped |=> !pslverr)
      else $error("error mapped");
   frame_bits_a: assert property ($rose(uart_txd) |->
      lowrun % bitlen == 0 && lowrun <= 9 * bitlen)
      else $error("bad low run");
   rts_three_wire_a: assert property (ctrl_q[C_THREEW] [*2] |-> uart_rts_n)
      else $error("request in three-wire");
   rts_full_a: assert property ((thr_q > 12'd1040) [*2] |-> uart_rts_n)
      else $error("request with no room");
   rts_room_a: assert property (room [*2] |-> !uart_rts_n)
      else $error("request high with room");
   wake_rise_a: assert property (ctrl_q[C_SLEEP] && stir |-> ##[1:4] wake)
      else $error("no wake");
   wake_quiet_a: assert property (!ctrl_q[C_SLEEP] [*2] |-> !wake)
      else $error("wake while awake");
endmodule : hciu_uart_chk

bind hciu_uart hciu_uart_chk hciu_uart_chk_i (.*);

// ===== hciu_host.sv
`timescale 1ns/10ps
module hciu_host #(
   parameter int BIT = 64
) (
   input  wire logic       pclk,      // Clock
   input  wire logic       txd,       // Device transmit line
   input  wire logic       hold,      // Hold off the device
   output      logic       rxd,       // Device receive line
   output      logic       cts_n,     // Clear to send, low
   output      logic       got,       // One-cycle byte strobe
   output      logic [8:0] got_byte   // Stop bit and data
);
   initial begin
      rxd      = 1'b1;
      got      = 1'b0;
      got_byte = 9'h000;
   end

   // Clear follows hold
   assign cts_n = hold;

   // One character, idle high after
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge pclk);
      end
   endtask : send

   // Sample at bit centres, stop bit kept
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge pclk);
         got_byte[i] <= txd;
      end
      got <= 1'b1;
      @(posedge pclk);
      got <= 1'b0;
   end
endmodule : hciu_host

// ===== hciu_uart_tb.sv
`timescale 1ns/10ps
module hciu_uart_tb import hciu_pkg::*;;
   localparam int BIT = 64;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, hold = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, uart_rxd, uart_txd, uart_cts_n, uart_rts_n, wake, got;
   logic [8:0]  got_byte;
   logic [64:0] aq[$];
   logic [64:0] e;
   logic [8:0]  wq[$];
   logic [7:0]  b;
   int          failures = 0, check_count = 0, n;

   hciu_uart hciu_uart_i (.*);
   hciu_host #(.BIT(BIT)) hciu_host_i (.pclk, .txd(uart_txd), .hold, .rxd(uart_rxd),
      .cts_n(uart_cts_n), .got, .got_byte);

   always #4 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic test_done;
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // One APB transfer
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] v, logic er = 1'b0);
      aq.push_back({er, m, v});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic tx(logic [7:0] d);
      wq.push_back({1'b1, d});
      apb(1'b1, REG_TXDATA, {24'h0, d});
   endtask : tx

   // Wait for queued characters
   task automatic drain;
      n = 0;
      while (wq.size() != 0 && n < 40 * BIT) begin
         @(posedge pclk);
         n++;
      end
      repeat (BIT) @(posedge pclk);
      check("drain", wq.size(), 0);
   endtask : drain

   // Idle for three bits
   task automatic quiet;
      n = 0;
      repeat (3 * BIT) begin
         @(posedge pclk);
         n += int'(!uart_txd);
      end
      check("quiet", n, 0);
   endtask : quiet

   ////////////////////////////////////////////////////////////////////////////
   // Pair reads and characters with notes
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = aq.pop_front();
         check("prdata", prdata & e[63:32], e[31:0]);
         check("pslverr", pslverr, e[64]);
      end
      if (got === 1'b1) check("wire", got_byte, wq.pop_front());
   end

   // Watchdog
   initial begin
      repeat (80000) @(posedge pclk);
      failures++;
      test_done();
   end

   initial begin
      void'($urandom(32'h128d068c));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_BAUD, 32'hffff, 32'(DIV_DEFAULT));
      rd(REG_CTRL, 32'h3f, 32'h1);
      rd(8'h24, 32'hffffffff, 32'h0, 1'b1);
      apb(1'b1, REG_BAUD, 32'h4);
      apb(1'b1, REG_BAUD, 32'h0);
      rd(REG_BAUD, 32'hffff, 32'h4);
      for (int i = 0; i < 4; i++) tx(8'($urandom));
      drain();
      // Framing escapes
      apb(1'b1, REG_CTRL, 32'h9);
      wq = {9'h1db, 9'h1dc, 9'h1db, 9'h1dd};
      apb(1'b1, REG_TXDATA, 32'hc0);
      apb(1'b1, REG_TXDATA, 32'hdb);
      drain();
      // Clear hold-off and latency
      apb(1'b1, REG_CTRL, 32'h1);
      hold <= 1'b1;
      tx(8'h5a);
      quiet();
      hold <= 1'b0;
      n = 0;
      while (uart_txd === 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      check("cts_lat", n <= BIT * 3 / 2, 1);
      drain();
      // Receive path and empty read
      b = 8'($urandom);
      hciu_host_i.send(b);
      rd(REG_RXDATA, 32'h1ff, {23'h0, 1'b1, b});
      rd(REG_RXDATA, 32'h100, 32'h0);
      // Software flow control
      apb(1'b1, REG_CTRL, 32'h5);
      hciu_host_i.send(CH_XOFF);
      tx(8'h3c);
      quiet();
      rd(REG_STATUS, 32'h40, 32'h40);
      hciu_host_i.send(CH_XON);
      drain();
      rd(REG_RXDATA, 32'h100, 32'h0);
      // Request line, then three-wire
      apb(1'b1, REG_RTSTHR, 32'h411);
      repeat (2) @(posedge pclk);
      check("rts_full", uart_rts_n, 1'b1);
      apb(1'b1, REG_RTSTHR, 32'h0);
      repeat (2) @(posedge pclk);
      check("rts_room", uart_rts_n, 1'b0);
      apb(1'b1, REG_CTRL, 32'h3);
      hold <= 1'b1;
      tx(8'ha5);
      check("rts_3w", uart_rts_n, 1'b1);
      drain();
      // Wake by receive activity
      apb(1'b1, REG_CTRL, 32'h21);
      hciu_host_i.send(8'h00);
      check("wake", wake, 1'b1);
      rd(REG_STATUS, 32'h4, 32'h4);
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      check("unwake", wake, 1'b0);
      // Rate detection
      apb(1'b1, REG_CTRL, 32'h11);
      hciu_host_i.send(8'h01);
      rd(REG_AUTOBD, 32'h1ffff, 32'h4);
      test_done();
   end
endmodule : hciu_uart_tb
